// file: verilog/timer3_control_logic.sv
// timer 3 core: control register, 16-bit or split 8-bit auto-reload counting, capture and interrupts
//
// Behaviour
// - high-byte wrap from ff to the reload byte sets the high overflow flag
// - in 16-bit mode the high flag rises when the count wraps from ffff to the reload value
// - with the timer interrupt enabled, a set high flag requests the interrupt
// - hardware never clears either overflow flag; software writes zero to acknowledge
// - low-byte wrap from ff sets the low overflow flag in every mode
// - low irq enable plus timer interrupt enable interrupts on every low overflow
// - capture enable bit zero disables capture, one enables it
// - split bit zero gives one 16-bit timer, one gives two 8-bit timers
// - run bit starts the timer; in split mode it gates only the high byte
// - control bit one is unused, reads zero, writes ignored
// - external select zero picks system clock /12, one picks synchronised external /8
// - in split mode external select feeds both bytes, fast bits may override
// - each 16-bit overflow loads the 16-bit reload value into the count
// - capture: external /8 falling edge copies count to reload and sets high flag
// - split mode: each byte reloads from its own reload byte on overflow
// - a byte's fast clock bit picks undivided system clock, else the selected clock
`include "timer3_defines.svh"
module timer3_control_logic (
    // clock and reset
    input  wire logic               REF_CLK_IN,
    input  wire logic               RESET_N_IN,
    // external clock pin
    input  wire logic               EXT_CLK_IN,
    // register port
    input  wire timer3_pkg::byte_t  ADDR_IN,
    input  wire timer3_pkg::byte_t  WR_DATA_IN,
    input  wire logic               WR_STROBE_IN,
    input  wire logic               RD_STROBE_IN,
    output timer3_pkg::byte_t       RD_DATA_OUT,
    // clock control bits and interrupt enable held elsewhere
    input  wire logic               HIGH_BYTE_FAST_CLOCK_IN,
    input  wire logic               LOW_BYTE_FAST_CLOCK_IN,
    input  wire logic               TIMER_IRQ_ENABLE_IN,
    // interrupts
    output logic                    TIMER_IRQ_OUT,
    output logic                    EVENT_IRQ_OUT
);
    import timer3_pkg::*;

    // control register fields
    logic  high_overflow_flag_reg;
    logic  low_overflow_flag_reg;
    logic  low_overflow_irq_enable_reg;
    logic  capture_mode_enable_reg;
    logic  split_mode_select_reg;
    logic  run_control_reg;
    logic  external_clock_select_reg;

    // count and reload
    word_t count_reg;
    word_t count_next;
    word_t reload_reg;
    word_t reload_next;

    // strobes and events
    logic  wr_ctrl;
    logic  wr_reload_lo;
    logic  wr_reload_hi;
    logic  wr_count_lo;
    logic  wr_count_hi;
    logic  wr_evt_clear;
    logic  wr_evt_enable;
    logic  tick_lo;
    logic  tick_hi;
    logic  high_ovf_evt;
    logic  low_ovf_evt;
    logic  capture_evt;
    evt_t  evt_vec;
    evt_t  evt_status;
    evt_t  evt_enable;
    byte_t rd_data_next;
    byte_t rd_data_reg;
    logic  timer_irq_reg;

    timer3_tick_if ticks ();

    // tick generation
    timer3_prescaler u_prescaler (
        .clk_in     (REF_CLK_IN),
        .rst_n_in   (RESET_N_IN),
        .ext_clk_in (EXT_CLK_IN),
        .ticks      (ticks.source)
    );

    // address decode of writes
    assign wr_ctrl       = WR_STROBE_IN && (ADDR_IN == `T3_CTRL_ADDR);
    assign wr_reload_lo  = WR_STROBE_IN && (ADDR_IN == `T3_RELOAD_LO_ADDR);
    assign wr_reload_hi  = WR_STROBE_IN && (ADDR_IN == `T3_RELOAD_HI_ADDR);
    assign wr_count_lo   = WR_STROBE_IN && (ADDR_IN == `T3_COUNT_LO_ADDR);
    assign wr_count_hi   = WR_STROBE_IN && (ADDR_IN == `T3_COUNT_HI_ADDR);
    assign wr_evt_clear  = WR_STROBE_IN && (ADDR_IN == `T3_EVT_CLEAR_ADDR);
    assign wr_evt_enable = WR_STROBE_IN && (ADDR_IN == `T3_EVT_ENABLE_ADDR);

    // per-byte clock source; external select reaches both bytes
    assign tick_lo = select_tick(LOW_BYTE_FAST_CLOCK_IN, external_clock_select_reg,
                                 ticks.sys12_tick, ticks.ext8_tick);
    assign tick_hi = select_tick(HIGH_BYTE_FAST_CLOCK_IN, external_clock_select_reg,
                                 ticks.sys12_tick, ticks.ext8_tick);

    // capture event on the falling edge of the external /8 clock
    assign capture_evt = capture_mode_enable_reg && ticks.ext8_tick;

    // counting and overflow detection
    always_comb begin
        count_next   = count_reg;
        high_ovf_evt = 1'b0;
        low_ovf_evt  = 1'b0;
        if (split_mode_select_reg) begin
            // low byte always runs in split mode
            if (tick_lo) begin
                if (count_reg[7:0] == 8'hff) begin
                    count_next[7:0] = reload_reg[7:0];
                    low_ovf_evt     = 1'b1;
                end else begin
                    count_next[7:0] = count_reg[7:0] + 8'h01;
                end
            end
            // high byte gated by run control
            if (run_control_reg && tick_hi) begin
                if (count_reg[15:8] == 8'hff) begin
                    count_next[15:8] = reload_reg[15:8];
                    high_ovf_evt     = 1'b1;
                end else begin
                    count_next[15:8] = count_reg[15:8] + 8'h01;
                end
            end
        end else if (run_control_reg && tick_lo) begin
            if (count_reg == 16'hffff) begin
                count_next   = reload_reg;
                high_ovf_evt = 1'b1;
                low_ovf_evt  = 1'b1;
            end else begin
                count_next  = count_reg + 16'h0001;
                low_ovf_evt = (count_reg[7:0] == 8'hff);
            end
        end
        // software writes to a count byte win over counting
        if (wr_count_lo) begin
            count_next[7:0] = WR_DATA_IN;
        end
        if (wr_count_hi) begin
            count_next[15:8] = WR_DATA_IN;
        end
    end

    // reload value: capture beats a software write
    always_comb begin
        reload_next = reload_reg;
        if (wr_reload_lo) begin
            reload_next[7:0] = WR_DATA_IN;
        end
        if (wr_reload_hi) begin
            reload_next[15:8] = WR_DATA_IN;
        end
        if (capture_evt) begin
            reload_next = count_reg;
        end
    end

    // count and reload registers
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            count_reg  <= 16'h0000;
            reload_reg <= 16'h0000;
        end else begin
            count_reg  <= count_next;
            reload_reg <= reload_next;
        end
    end

    // overflow flags: set wins over a software clear, hardware never clears
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            high_overflow_flag_reg <= 1'b0;
            low_overflow_flag_reg  <= 1'b0;
        end else begin
            if (high_ovf_evt || capture_evt) begin
                high_overflow_flag_reg <= 1'b1;
            end else if (wr_ctrl) begin
                high_overflow_flag_reg <= WR_DATA_IN[`T3_HIGH_FLAG_BIT];
            end
            if (low_ovf_evt) begin
                low_overflow_flag_reg <= 1'b1;
            end else if (wr_ctrl) begin
                low_overflow_flag_reg <= WR_DATA_IN[`T3_LOW_FLAG_BIT];
            end
        end
    end

    // software-owned control fields; the unused bit has no storage
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            low_overflow_irq_enable_reg <= 1'b0;
            capture_mode_enable_reg     <= 1'b0;
            split_mode_select_reg       <= 1'b0;
            run_control_reg             <= 1'b0;
            external_clock_select_reg   <= 1'b0;
        end else if (wr_ctrl) begin
            low_overflow_irq_enable_reg <= WR_DATA_IN[`T3_LOW_IRQ_EN_BIT];
            capture_mode_enable_reg     <= WR_DATA_IN[`T3_CAPTURE_EN_BIT];
            split_mode_select_reg       <= WR_DATA_IN[`T3_SPLIT_BIT];
            run_control_reg             <= WR_DATA_IN[`T3_RUN_BIT];
            external_clock_select_reg   <= WR_DATA_IN[`T3_XCLK_BIT];
        end
    end

    // timer interrupt request from the overflow flags
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            timer_irq_reg <= 1'b0;
        end else begin
            timer_irq_reg <= TIMER_IRQ_ENABLE_IN &&
                             (high_overflow_flag_reg ||
                              (low_overflow_irq_enable_reg && low_overflow_flag_reg));
        end
    end

    // event vector for the sticky status block
    always_comb begin
        evt_vec                      = 3'h0;
        evt_vec[`T3_EVT_HIGH_BIT]    = high_ovf_evt;
        evt_vec[`T3_EVT_LOW_BIT]     = low_ovf_evt;
        evt_vec[`T3_EVT_CAPTURE_BIT] = capture_evt;
    end

    timer3_event_irq u_event_irq (
        .clk_in       (REF_CLK_IN),
        .rst_n_in     (RESET_N_IN),
        .evt_in       (evt_vec),
        .wr_clear_in  (wr_evt_clear),
        .wr_enable_in (wr_evt_enable),
        .wr_data_in   (WR_DATA_IN[2:0]),
        .status_out   (evt_status),
        .enable_out   (evt_enable),
        .irq_out      (EVENT_IRQ_OUT)
    );

    // read mux; unmapped and write-only addresses read zero
    always_comb begin
        rd_data_next = 8'h00;
        unique case (ADDR_IN)
            `T3_CTRL_ADDR: begin
                rd_data_next = {high_overflow_flag_reg, low_overflow_flag_reg,
                                low_overflow_irq_enable_reg, capture_mode_enable_reg,
                                split_mode_select_reg, run_control_reg,
                                1'b0, external_clock_select_reg};
            end
            `T3_RELOAD_LO_ADDR:  rd_data_next = reload_reg[7:0];
            `T3_RELOAD_HI_ADDR:  rd_data_next = reload_reg[15:8];
            `T3_COUNT_LO_ADDR:   rd_data_next = count_reg[7:0];
            `T3_COUNT_HI_ADDR:   rd_data_next = count_reg[15:8];
            `T3_EVT_STATUS_ADDR: rd_data_next = {5'h00, evt_status};
            `T3_EVT_ENABLE_ADDR: rd_data_next = {5'h00, evt_enable};
            default:             rd_data_next = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rd_data_reg <= 8'h00;
        end else begin
            rd_data_reg <= RD_STROBE_IN ? rd_data_next : 8'h00;
        end
    end

    assign RD_DATA_OUT   = rd_data_reg;
    assign TIMER_IRQ_OUT = timer_irq_reg;

    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    // named steps of the overflow behaviour
    sequence split_high_wrap_s;
        split_mode_select_reg && run_control_reg && tick_hi && (count_reg[15:8] == 8'hff);
    endsequence
    sequence wrap16_s;
        !split_mode_select_reg && run_control_reg && tick_lo && (count_reg == 16'hffff)
        && !wr_count_lo && !wr_count_hi;
    endsequence
    sequence low_wrap_s;
        tick_lo && (count_reg[7:0] == 8'hff) && (split_mode_select_reg || run_control_reg);
    endsequence

    high_split_set_a: assert property (split_high_wrap_s |=> high_overflow_flag_reg)
        else $error("high flag not set on split high wrap");
    wrap16_reload_a: assert property (wrap16_s |=> high_overflow_flag_reg && low_overflow_flag_reg
        && (count_reg == $past(reload_reg)))
        else $error("16-bit wrap did not reload or flag");
    timer_irq_a: assert property (high_overflow_flag_reg && TIMER_IRQ_ENABLE_IN |=> TIMER_IRQ_OUT)
        else $error("timer interrupt missing for high flag");
    flag_hold_a: assert property (high_overflow_flag_reg && !wr_ctrl |=> high_overflow_flag_reg)
        else $error("high flag cleared without software");
    low_hold_a: assert property (low_overflow_flag_reg && !wr_ctrl |=> low_overflow_flag_reg)
        else $error("low flag cleared without software");
    low_set_a: assert property (low_wrap_s |=> low_overflow_flag_reg)
        else $error("low flag not set on low wrap");
    low_irq_a: assert property (low_overflow_flag_reg && low_overflow_irq_enable_reg
        && TIMER_IRQ_ENABLE_IN |=> TIMER_IRQ_OUT)
        else $error("low overflow interrupt missing");
    capture_copy_a: assert property (capture_mode_enable_reg && ticks.ext8_tick
        |=> (reload_reg == $past(count_reg)) && high_overflow_flag_reg)
        else $error("capture did not copy count");
    capture_off_a: assert property (!capture_mode_enable_reg && !wr_reload_lo && !wr_reload_hi
        |=> $stable(reload_reg))
        else $error("reload changed while capture disabled");
    split_low_run_a: assert property (split_mode_select_reg && !run_control_reg && tick_lo
        && (count_reg[7:0] != 8'hff) && !wr_count_lo |=> count_reg[7:0] == $past(count_reg[7:0]) + 8'h01)
        else $error("split low byte stopped without run");
    stopped_16_a: assert property (!split_mode_select_reg && !run_control_reg && !wr_count_lo
        && !wr_count_hi |=> $stable(count_reg))
        else $error("16-bit count moved while stopped");
    unused_bit_a: assert property (RD_STROBE_IN && (ADDR_IN == `T3_CTRL_ADDR) |=> !RD_DATA_OUT[1])
        else $error("unused control bit read as one");
    fast_tick_a: assert property (split_mode_select_reg && LOW_BYTE_FAST_CLOCK_IN && !wr_count_lo
        && (count_reg[7:0] != 8'hff) |=> count_reg[7:0] == $past(count_reg[7:0]) + 8'h01)
        else $error("fast low clock not counting every cycle");
endmodule : timer3_control_logic

// file: verilog/timer3_defines.svh
// register offsets, field positions and divider counts of the timer 3 control logic
`ifndef TIMER3_DEFINES_SVH
`define TIMER3_DEFINES_SVH

// register byte offsets
`define T3_CTRL_ADDR        8'h91
`define T3_RELOAD_LO_ADDR   8'h92
`define T3_RELOAD_HI_ADDR   8'h93
`define T3_COUNT_LO_ADDR    8'h94
`define T3_COUNT_HI_ADDR    8'h95
`define T3_EVT_STATUS_ADDR  8'h96
`define T3_EVT_CLEAR_ADDR   8'h97
`define T3_EVT_ENABLE_ADDR  8'h98

// control register field positions
`define T3_HIGH_FLAG_BIT    7
`define T3_LOW_FLAG_BIT     6
`define T3_LOW_IRQ_EN_BIT   5
`define T3_CAPTURE_EN_BIT   4
`define T3_SPLIT_BIT        3
`define T3_RUN_BIT          2
`define T3_UNUSED_BIT       1
`define T3_XCLK_BIT         0
`define T3_CTRL_RESET       8'h00

// event status layout
`define T3_EVT_HIGH_BIT     0
`define T3_EVT_LOW_BIT      1
`define T3_EVT_CAPTURE_BIT  2

// divider terminal counts
`define T3_SYS_DIV_LAST     4'hb
`define T3_EXT_DIV_LAST     3'h7

`endif

// file: verilog/timer3_pkg.sv
// types and shared decode functions of the timer 3 control logic
package timer3_pkg;

    typedef logic [7:0]  byte_t;
    typedef logic [15:0] word_t;
    typedef logic [2:0]  evt_t;

    // clock source of one byte counter: fast clock wins, else external or divided system clock
    function automatic logic select_tick(input logic fast, input logic xclk,
                                         input logic sys12_tick, input logic ext8_tick);
        select_tick = fast ? 1'b1 : (xclk ? ext8_tick : sys12_tick);
    endfunction : select_tick

endpackage : timer3_pkg

// file: verilog/timer3_tick_if.sv
// count ticks passed from the prescaler to the timer core
interface timer3_tick_if;
    logic sys12_tick;
    logic ext8_tick;

    modport source (output sys12_tick, output ext8_tick);
    modport sink   (input  sys12_tick, input  ext8_tick);
endinterface : timer3_tick_if

// file: verilog/timer3_prescaler.sv
// system clock divide by 12 and synchronised external clock divide by 8
`include "timer3_defines.svh"
module timer3_prescaler (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    // external clock pin
    input  wire logic         ext_clk_in,
    // ticks
    timer3_tick_if.source     ticks
);
    import timer3_pkg::*;

    logic [3:0] sys_cnt_reg;
    logic       sys_tick_reg;
    logic       ext_meta_reg;
    logic       ext_sync_reg;
    logic       ext_prev_reg;
    logic [2:0] ext_cnt_reg;
    logic       ext_tick_reg;
    logic       ext_rise;

    // system clock divided by 12, one tick per twelve cycles
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sys_cnt_reg  <= 4'h0;
            sys_tick_reg <= 1'b0;
        end else begin
            sys_cnt_reg  <= (sys_cnt_reg == `T3_SYS_DIV_LAST) ? 4'h0 : sys_cnt_reg + 4'h1;
            sys_tick_reg <= (sys_cnt_reg == `T3_SYS_DIV_LAST);
        end
    end

    // two-stage synchroniser, then edge memory
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            ext_meta_reg <= ext_clk_in;
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
        end
    end

    assign ext_rise = ext_sync_reg & ~ext_prev_reg;

    // external divide by 8; tick at the falling edge of the divided clock
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ext_cnt_reg  <= 3'h0;
            ext_tick_reg <= 1'b0;
        end else begin
            ext_cnt_reg  <= ext_rise ? ext_cnt_reg + 3'h1 : ext_cnt_reg;
            ext_tick_reg <= ext_rise && (ext_cnt_reg == `T3_EXT_DIV_LAST);
        end
    end

    assign ticks.sys12_tick = sys_tick_reg;
    assign ticks.ext8_tick  = ext_tick_reg;

    // divided system tick never comes twice within eight cycles
    sys12_gap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        sys_tick_reg |=> !sys_tick_reg [*8]) else $error("divide-by-12 tick too early");
endmodule : timer3_prescaler

// file: verilog/timer3_event_irq.sv
// sticky event status, write-one clear and enable mask with one level interrupt
`include "timer3_defines.svh"
module timer3_event_irq (
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    // events and software writes
    input  wire timer3_pkg::evt_t  evt_in,
    input  wire logic              wr_clear_in,
    input  wire logic              wr_enable_in,
    input  wire timer3_pkg::evt_t  wr_data_in,
    // state
    output timer3_pkg::evt_t       status_out,
    output timer3_pkg::evt_t       enable_out,
    output logic                   irq_out
);
    import timer3_pkg::*;

    evt_t status_reg;
    evt_t enable_reg;
    logic irq_reg;

    // set wins over a clear in the same cycle
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_reg <= 3'h0;
        end else begin
            status_reg <= (status_reg & ~(wr_clear_in ? wr_data_in : 3'h0)) | evt_in;
        end
    end

    // enable mask and registered interrupt
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enable_reg <= 3'h0;
            irq_reg    <= 1'b0;
        end else begin
            if (wr_enable_in) begin
                enable_reg <= wr_data_in;
            end
            irq_reg <= |(status_reg & enable_reg);
        end
    end

    assign status_out = status_reg;
    assign enable_out = enable_reg;
    assign irq_out    = irq_reg;
endmodule : timer3_event_irq

// file: testbench/tb_timer3_control_logic.sv
// self-checking bench for the timer 3 control logic
module tb_timer3_control_logic;
    timeunit 1ns;
    timeprecision 100ps;
    import timer3_pkg::*;

    typedef struct {byte_t a; byte_t d; byte_t e;} row_t;

    logic  clk, rst_n, ext_clk, ext_on, wr, rd, hi_fast, lo_fast, irq_en;
    byte_t addr, wdata, rdata, v;
    wire   byte_t rd_data;
    wire   logic  timer_irq, event_irq;
    int    err_total, num_checks, i, ext_cnt;

    // register rows: address, write value, expected read back
    row_t rows[11] = '{'{8'h91, 8'hff, 8'hfd}, '{8'h91, 8'h00, 8'h00}, '{8'h92, 8'h34, 8'h34},
                       '{8'h93, 8'h12, 8'h12}, '{8'h94, 8'hfd, 8'hfd}, '{8'h95, 8'hff, 8'hff},
                       '{8'h98, 8'h07, 8'h07}, '{8'h97, 8'hff, 8'h00}, '{8'h99, 8'h5a, 8'h00},
                       '{8'h96, 8'hff, 8'h00}, '{8'h90, 8'h11, 8'h00}};

    timer3_control_logic dut (
        .REF_CLK_IN(clk), .RESET_N_IN(rst_n), .EXT_CLK_IN(ext_clk), .ADDR_IN(addr), .WR_DATA_IN(wdata),
        .WR_STROBE_IN(wr), .RD_STROBE_IN(rd), .RD_DATA_OUT(rd_data), .HIGH_BYTE_FAST_CLOCK_IN(hi_fast),
        .LOW_BYTE_FAST_CLOCK_IN(lo_fast), .TIMER_IRQ_ENABLE_IN(irq_en), .TIMER_IRQ_OUT(timer_irq),
        .EVENT_IRQ_OUT(event_irq));

    // 40 MHz system clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // slow external clock, toggles every 3 system clocks while enabled
    always @(posedge clk) begin
        ext_cnt <= (ext_cnt == 2) ? 0 : ext_cnt + 1;
        if (ext_on && ext_cnt == 2) ext_clk <= ~ext_clk;
    end

    task automatic check(input byte_t seen, input byte_t exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr_reg(input byte_t a, input byte_t d);
        @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
        @(posedge clk) wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input byte_t a, output byte_t d);
        @(posedge clk) begin rd <= 1'b1; addr <= a; end
        @(posedge clk) rd <= 1'b0;
        #1 d = rd_data;
    endtask : rd_reg

    task automatic wait_irq();
        for (int k = 0; k < 400 && timer_irq !== 1'b1; k++) @(posedge clk);
        #1 check(byte_t'(timer_irq), 8'h01);
    endtask : wait_irq

    task automatic final_report();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    // watchdog
    initial begin
        #(20000 * 25);
        err_total++;
        final_report();
    end

    initial begin
        {clk, rst_n, ext_clk, ext_on, wr, rd, hi_fast, lo_fast, irq_en} = '0;
        {addr, wdata, err_total, num_checks, ext_cnt} = '0;
        repeat (3) @(posedge clk);
        #1 check({rd_data[7:2], timer_irq, event_irq}, 8'h00);
        @(posedge clk) rst_n <= 1'b1;
        rd_reg(8'h91, v); check(v, 8'h00);
        for (i = 0; i < 11; i++) begin
            wr_reg(rows[i].a, rows[i].d);
            rd_reg(rows[i].a, v); check(v, rows[i].e);
        end
        // 16-bit wrap from fffd, fast clock
        @(posedge clk) begin lo_fast <= 1'b1; irq_en <= 1'b1; end
        wr_reg(8'h91, 8'h04);
        wait_irq();
        rd_reg(8'h91, v); check(v, 8'hc4);
        rd_reg(8'h95, v); check(v, 8'h12);
        rd_reg(8'h96, v); check(v, 8'h03);
        check(byte_t'(event_irq), 8'h01);
        repeat (30) @(posedge clk);
        rd_reg(8'h91, v); check(v, 8'hc4);
        @(posedge clk) irq_en <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check(byte_t'(timer_irq), 8'h00);
        @(posedge clk) irq_en <= 1'b1;
        wr_reg(8'h91, 8'h00);
        wr_reg(8'h97, 8'h03);
        repeat (2) @(posedge clk);
        #1 check(byte_t'({timer_irq, event_irq}), 8'h00);
        rd_reg(8'h96, v); check(v, 8'h00);
        // split mode, high byte stopped, low byte runs
        @(posedge clk) hi_fast <= 1'b1;
        wr_reg(8'h91, 8'h08);
        wr_reg(8'h94, 8'hfe);
        wr_reg(8'h95, 8'hfe);
        repeat (10) @(posedge clk);
        rd_reg(8'h91, v); check(v, 8'h48);
        rd_reg(8'h95, v); check(v, 8'hfe);
        rd_reg(8'h94, v); check(byte_t'(v >= 8'h34 && v <= 8'h50), 8'h01);
        check(byte_t'(timer_irq), 8'h00);
        wr_reg(8'h91, 8'h68);
        wait_irq();
        // drop the low request first so the next wait sees a fresh high request
        wr_reg(8'h91, 8'h08);
        repeat (2) @(posedge clk);
        #1 check(byte_t'(timer_irq), 8'h00);
        wr_reg(8'h91, 8'h0c);
        wait_irq();
        rd_reg(8'h91, v); check(v & 8'h80, 8'h80);
        rd_reg(8'h95, v); check(byte_t'(v >= 8'h12 && v <= 8'h30), 8'h01);
        // divided system clock, 16-bit mode
        @(posedge clk) begin hi_fast <= 1'b0; lo_fast <= 1'b0; end
        wr_reg(8'h91, 8'h00);
        wr_reg(8'h94, 8'h00);
        wr_reg(8'h95, 8'h00);
        wr_reg(8'h91, 8'h04);
        repeat (120) @(posedge clk);
        wr_reg(8'h91, 8'h00);
        rd_reg(8'h94, v); check(byte_t'(v >= 8'h09 && v <= 8'h0b), 8'h01);
        rdata = v;
        // capture from the external clock divided by 8; the stopped count is copied
        wr_reg(8'h91, 8'h10);
        @(posedge clk) ext_on <= 1'b1;
        wait_irq();
        rd_reg(8'h92, v); check(v, rdata);
        rd_reg(8'h93, v); check(v, 8'h00);
        rd_reg(8'h96, v); check(v & 8'h04, 8'h04);
        final_report();
    end
endmodule : tb_timer3_control_logic
